// >>> design/sswp_pkg.sv
package sswp_pkg;

    // data widths of the device variants
    localparam int NARROW_DATA_W = 8;
    localparam int X9_DATA_W     = 9;
    localparam int X18_DATA_W    = 18;
    localparam int X36_DATA_W    = 36;

    // address inputs needed per variant
    localparam int ADDR_W_X8_X9  = 22;
    localparam int ADDR_W_X18    = 21;
    localparam int ADDR_W_X36    = 20;

    // write mask lane layout
    localparam int NIBBLE_W      = 4;
    localparam int NIBBLE_SELS   = 2;
    localparam int BYTE_LANE_W   = 9;
    localparam int BYTE_SELS     = 4;

    // input synchroniser depth
    localparam int SYNC_STAGES   = 3;

    // read drivers float out of reset
    localparam logic OE_FLOAT    = 1'b1;
    localparam logic OE_DRIVE    = 1'b0;

endpackage : sswp_pkg

// >>> design/sswp_mem_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sswp_mem_if #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 20,
    parameter int LANES  = 4
);
    logic              we;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0]  wen;
    logic              re;
    logic [ADDR_W-1:0] raddr;
    logic [DATA_W-1:0] rdata;

    modport ctrl (output we, output waddr, output wdata, output wen,
                  output re, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input wen,
                  input re, input raddr, output rdata);
endinterface : sswp_mem_if

`default_nettype wire

// >>> design/sswp_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sswp_sync import sswp_pkg::*; #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,  // core clock
    input  wire logic             rst,       // async reset, high
    input  wire logic [WIDTH-1:0] async_in,  // pin levels
    output logic      [WIDTH-1:0] stable     // filtered level
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] stable_q;
    logic [WIDTH-1:0] agree;

    // only s2 and s3 are compared; s1 may still be metastable
    assign agree  = ~(s2_q ^ s3_q);
    assign stable = stable_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_q     <= '0;
            s2_q     <= '0;
            s3_q     <= '0;
            stable_q <= '0;
        end else begin
            s1_q     <= async_in;
            s2_q     <= s1_q;
            s3_q     <= s2_q;
            stable_q <= (agree & s3_q) | (~agree & stable_q);
        end
    end
endmodule : sswp_sync

`default_nettype wire

// >>> design/sswp_mem.sv
`timescale 1ns/1ps
`default_nettype none

module sswp_mem import sswp_pkg::*; #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 20,
    parameter int LANE_W = 9,
    parameter int LANES  = 4
) (
    input  wire logic core_clk,  // core clock
    input  wire logic rst,       // async reset, high
    sswp_mem_if.mem   port       // one burst-beat array
);
    logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] rdata_q;

    assign port.rdata = rdata_q;

    if (LANES * LANE_W < DATA_W) begin : g_bad_cfg
        $error("sswp_mem: lanes do not cover the data word");
    end

    // one process owns the array; only enabled lanes are touched, the rest keep old contents
    always_ff @(posedge core_clk) begin
        if (port.we) begin
            for (int b = 0; b < DATA_W; b++) begin
                if (port.wen[b / LANE_W]) begin
                    mem_q[port.waddr][b] <= port.wdata[b];
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (port.re) begin
            rdata_q <= mem_q[port.raddr];
        end
    end
endmodule : sswp_mem

`default_nettype wire

// >>> design/sswp_top.sv
// Functional notes
// R01: write data taken on positive clock rise, then negative clock rise
// R02: write select low at positive clock rise starts a write
// R03: write select high: write port deselected, data ignored
// R04: eight-bit variant: nibble selects gate nibbles each beat; unselected nibbles kept
// R05: nibble select 0 covers bits 3..0, select 1 bits 7..4
// R06: nibble selects sampled on same edge as their data beat
// R07: wider variants: byte selects gate bytes each beat; unselected bytes kept
// R08: byte selects cover nine-bit lanes 8..0, 17..9, 26..18, 35..27
// R09: byte selects sampled on same edge as their data beat
// R10: shared address: read at positive rise, write at negative rise
// R11: address of a deselected port is ignored
// R12: two equal arrays, one per beat; 22, 21 or 20 address bits
// R13: read select low at positive rise starts two-beat read burst
// R14: read deselected: finish pending access, then float read data
// R15: every access begins on a positive clock rise
// R16: controller may select read and write in the same cycle
// R17: write updates only lanes whose selects were low for that beat
`timescale 1ns/1ps
`default_nettype none

module sswp_top import sswp_pkg::*; #(
    parameter int DATA_W = X36_DATA_W,
    parameter int ADDR_W = ADDR_W_X36
) (
    input  wire logic                   core_clk,              // 50 MHz core clock
    input  wire logic                   rst,                   // async reset, high
    input  wire logic                   pos_in_clk,            // positive input clock pin
    input  wire logic                   neg_in_clk,            // negative input clock pin
    input  wire logic                   write_port_select_n,   // write select, low
    input  wire logic                   read_port_select_n,    // read select, low
    input  wire logic [NIBBLE_SELS-1:0] nibble_write_select_n, // x8 lane selects, low
    input  wire logic [BYTE_SELS-1:0]   byte_write_select_n,   // wide lane selects, low
    input  wire logic [ADDR_W-1:0]      shared_addr,           // muxed address
    input  wire logic [DATA_W-1:0]      write_data,            // write data beats
    output logic      [DATA_W-1:0]      read_data,             // read data beats
    output logic                        read_data_oe_n         // low while driving
);
    localparam int LANE_W = (DATA_W == NARROW_DATA_W) ? NIBBLE_W : BYTE_LANE_W;
    localparam int LANES  = (DATA_W + LANE_W - 1) / LANE_W;
    localparam int IN_W   = 4 + NIBBLE_SELS + BYTE_SELS + ADDR_W + DATA_W;

    // [R12]
    if (!(((DATA_W == NARROW_DATA_W || DATA_W == X9_DATA_W) && ADDR_W == ADDR_W_X8_X9)
          || (DATA_W == X18_DATA_W && ADDR_W == ADDR_W_X18)
          || (DATA_W == X36_DATA_W && ADDR_W == ADDR_W_X36))) begin : g_bad_cfg
        $error("sswp_top: unsupported data/address width pair");
    end

    // all pins share one synchroniser so edges and data stay aligned
    logic [IN_W-1:0]        pins_s;
    logic                   k_s;
    logic                   kn_s;
    logic                   wps_s;
    logic                   rps_s;
    logic [NIBBLE_SELS-1:0] nws_s;
    logic [BYTE_SELS-1:0]   bws_s;
    logic [ADDR_W-1:0]      addr_s;
    logic [DATA_W-1:0]      wdata_s;

    // selects and the negative clock rest high; flipping them around the
    // synchroniser lets its cleared state read as idle pins, so reset leaves
    // no false negative edge and no phantom select behind
    localparam logic [IN_W-1:0] IDLE_FLIP = {1'b0, {(3 + NIBBLE_SELS + BYTE_SELS){1'b1}},
                                              {(ADDR_W + DATA_W){1'b0}}};

    logic [IN_W-1:0] pins_raw;
    logic [IN_W-1:0] pins_flip;

    assign pins_raw  = {pos_in_clk, neg_in_clk, write_port_select_n, read_port_select_n,
                        nibble_write_select_n, byte_write_select_n, shared_addr, write_data};
    assign pins_flip = pins_raw ^ IDLE_FLIP;

    sswp_sync #(.WIDTH(IN_W)) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (pins_flip),
        .stable   (pins_s)
    );

    assign {k_s, kn_s, wps_s, rps_s, nws_s, bws_s, addr_s, wdata_s} = pins_s ^ IDLE_FLIP;

    logic k_prev_q;
    logic kn_prev_q;
    wire  k_rise  = k_s & ~k_prev_q;
    wire  kn_rise = kn_s & ~kn_prev_q;

    // lane masks, active low
    logic [LANES-1:0] mask_n;
    if (DATA_W == NARROW_DATA_W) begin : g_nib
        assign mask_n = nws_s[LANES-1:0]; // [R04] [R05]
    end else begin : g_byte
        assign mask_n = bws_s[LANES-1:0]; // [R07] [R08]
    end

    // write side
    logic              wr_pend_q;
    logic [DATA_W-1:0] beat0_data_q;
    logic [LANES-1:0]  beat0_mask_q;
    logic [DATA_W-1:0] beat1_data_q;
    logic [LANES-1:0]  beat1_mask_q;
    logic [ADDR_W-1:0] waddr_q;
    logic              mem_we_q;

    wire wr_accept = k_rise & ~wps_s;                 // [R02] [R15]
    wire wr_second = kn_rise & wr_pend_q & ~k_rise;   // [R10] [R11]

    // read side
    logic              rd_re_q;
    logic [ADDR_W-1:0] raddr_q;
    logic              rd_pend_q;
    logic              beat1_pend_q;
    logic [DATA_W-1:0] hold1_q;
    logic [DATA_W-1:0] read_data_q;
    logic              oe_n_q;

    wire rd_accept = k_rise & ~rps_s;                 // [R13] [R15] [R16]

    sswp_mem_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANES(LANES)) arr0_if ();
    sswp_mem_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANES(LANES)) arr1_if ();

    // one array per burst beat, both written from one address [R12] [R17]
    assign arr0_if.we    = mem_we_q;
    assign arr0_if.waddr = waddr_q;
    assign arr0_if.wdata = beat0_data_q;
    assign arr0_if.wen   = ~beat0_mask_q;
    assign arr0_if.re    = rd_re_q;
    assign arr0_if.raddr = raddr_q;
    assign arr1_if.we    = mem_we_q;
    assign arr1_if.waddr = waddr_q;
    assign arr1_if.wdata = beat1_data_q;
    assign arr1_if.wen   = ~beat1_mask_q;
    assign arr1_if.re    = rd_re_q;
    assign arr1_if.raddr = raddr_q;

    sswp_mem #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANE_W(LANE_W), .LANES(LANES)) u_arr0 (
        .core_clk (core_clk),
        .rst      (rst),
        .port     (arr0_if)
    );

    sswp_mem #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANE_W(LANE_W), .LANES(LANES)) u_arr1 (
        .core_clk (core_clk),
        .rst      (rst),
        .port     (arr1_if)
    );

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            k_prev_q  <= 1'b0;
            kn_prev_q <= 1'b1;
        end else begin
            k_prev_q  <= k_s;
            kn_prev_q <= kn_s;
        end
    end

    // beat 0 on positive rise; deselect drops the pending write [R01] [R03] [R06] [R09]
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_pend_q    <= 1'b0;
            beat0_data_q <= '0;
            beat0_mask_q <= '1;
        end else if (k_rise) begin
            wr_pend_q <= ~wps_s;
            if (wr_accept) begin
                beat0_data_q <= wdata_s;
                beat0_mask_q <= mask_n;
            end
        end else if (wr_second) begin
            wr_pend_q <= 1'b0;
        end
    end

    // beat 1 and write address on negative rise [R01] [R06] [R09] [R10]
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            beat1_data_q <= '0;
            beat1_mask_q <= '1;
            waddr_q      <= '0;
            mem_we_q     <= 1'b0;
        end else begin
            mem_we_q <= wr_second;
            if (wr_second) begin
                beat1_data_q <= wdata_s;
                beat1_mask_q <= mask_n;
                waddr_q      <= addr_s;
            end
        end
    end

    // read address on positive rise only when selected [R10] [R11]
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_re_q <= 1'b0;
            raddr_q <= '0;
        end else begin
            rd_re_q <= rd_accept;
            if (rd_accept) begin
                raddr_q <= addr_s;
            end
        end
    end

    // burst out: beat 0 at next positive rise, beat 1 at following negative rise;
    // without a new read the drivers float at the positive rise after [R13] [R14]
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_pend_q    <= 1'b0;
            beat1_pend_q <= 1'b0;
            hold1_q      <= '0;
            read_data_q  <= '0;
            oe_n_q       <= OE_FLOAT;
        end else if (k_rise) begin
            rd_pend_q    <= ~rps_s;
            beat1_pend_q <= rd_pend_q;
            if (rd_pend_q) begin
                read_data_q <= arr0_if.rdata;
                hold1_q     <= arr1_if.rdata;
                oe_n_q      <= OE_DRIVE;
            end else begin
                oe_n_q      <= OE_FLOAT;
            end
        end else if (kn_rise && beat1_pend_q) begin
            read_data_q  <= hold1_q;
            beat1_pend_q <= 1'b0;
        end
    end

    assign read_data      = read_data_q;
    assign read_data_oe_n = oe_n_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // write side
    sequence s_wr_accept;
        k_rise && !wps_s;
    endsequence

    sequence s_wr_second;
        kn_rise && wr_pend_q && !k_rise;
    endsequence

    a_wr_start_pend: assert property (s_wr_accept |=> wr_pend_q) // [R02]
        else $error("accepted write did not become pending");

    a_wr_deselect: assert property (k_rise && wps_s |=> !wr_pend_q) // [R03]
        else $error("deselected write still pending");

    a_wr_ignored: assert property (k_rise && wps_s |=> // [R03]
            $stable(beat0_data_q) && $stable(beat0_mask_q))
        else $error("deselected write data or mask taken");

    a_beat0_capture: assert property (s_wr_accept |=> // [R01]
            beat0_data_q == $past(wdata_s) && beat0_mask_q == $past(mask_n))
        else $error("beat 0 data or mask not taken at positive rise");

    a_beat1_capture: assert property (s_wr_second |=> // [R10]
            mem_we_q && beat1_data_q == $past(wdata_s) && waddr_q == $past(addr_s))
        else $error("beat 1 or write address not taken at negative rise");

    a_beat1_mask: assert property (s_wr_second |=> // [R09]
            beat1_mask_q == $past(mask_n) && !wr_pend_q)
        else $error("beat 1 mask not taken with its data");

    a_write_cause: assert property (mem_we_q |-> $past(kn_rise) && $past(wr_pend_q)) // [R11]
        else $error("array written without accepted write");

    a_no_stray_we: assert property (!wr_pend_q |=> !mem_we_q) // [R11]
        else $error("array write without a pending write");

    a_lane_gate: assert property (mem_we_q |-> // [R17]
            arr1_if.wen == ~$past(mask_n) && arr0_if.wen == ~beat0_mask_q)
        else $error("lane enables differ from sampled selects");

    // read side
    sequence s_rd_accept;
        k_rise && !rps_s;
    endsequence

    sequence s_rd_beat1;
        kn_rise && beat1_pend_q && !k_rise;
    endsequence

    a_rd_addr_take: assert property (s_rd_accept |=> // [R10]
            rd_re_q && raddr_q == $past(addr_s))
        else $error("read address not taken at positive rise");

    a_rd_addr_hold: assert property (!rd_accept |=> !rd_re_q && $stable(raddr_q)) // [R11]
        else $error("read address taken while read port deselected");

    a_rd_beat0_out: assert property (k_rise && rd_pend_q |=> // [R12]
            read_data_q == $past(arr0_if.rdata) && beat1_pend_q)
        else $error("read beat 0 not taken from array 0");

    a_rd_beat1_out: assert property (s_rd_beat1 |=> // [R12]
            read_data_q == $past(hold1_q) && !beat1_pend_q)
        else $error("read beat 1 not taken from array 1");

    a_rd_burst: assert property (k_rise && rd_pend_q |=> !oe_n_q ##0 beat1_pend_q) // [R13]
        else $error("read burst did not start driving");

    a_rd_float: assert property (k_rise && !rd_pend_q |=> oe_n_q) // [R14]
        else $error("read drivers not floated after deselect");

    a_oe_steady: assert property (!k_rise |=> $stable(oe_n_q)) // [R14]
        else $error("read driver enable moved off a positive rise");

    a_begin_k: assert property ($rose(rd_pend_q) || $rose(wr_pend_q) |-> $past(k_rise)) // [R15]
        else $error("access began off a positive rise");

endmodule : sswp_top

`default_nettype wire

// >>> tb/sswp_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module sswp_ctrl_model import sswp_pkg::*; #(
    parameter int DATA_W = X36_DATA_W,
    parameter int ADDR_W = ADDR_W_X36
) (
    input  wire logic              core_clk,              // core clock
    input  wire logic [DATA_W-1:0] read_data,             // read beats
    input  wire logic              read_data_oe_n,        // low while driving
    output logic                   pos_in_clk,            // positive input clock
    output logic                   neg_in_clk,            // negative input clock
    output logic                   write_port_select_n,   // write select, low
    output logic                   read_port_select_n,    // read select, low
    output logic [NIBBLE_SELS-1:0] nibble_write_select_n, // x8 lane selects
    output logic [BYTE_SELS-1:0]   byte_write_select_n,   // wide lane selects
    output logic [ADDR_W-1:0]      shared_addr,           // muxed address
    output logic [DATA_W-1:0]      write_data             // write beats
);
    logic [DATA_W-1:0] seen_beat0;
    logic [DATA_W-1:0] seen_beat1;
    logic              seen_oe_n;

    // pin clocks stand still between frames
    initial begin
        pos_in_clk            = 1'b0;
        neg_in_clk            = 1'b1;
        write_port_select_n   = 1'b1;
        read_port_select_n    = 1'b1;
        nibble_write_select_n = '1;
        byte_write_select_n   = '1;
        shared_addr           = '0;
        write_data            = '0;
    end

    // one input clock period; released lines flip so stale values never look valid
    task automatic kcycle(input logic wn, input logic rn, input logic [ADDR_W-1:0] ard,
                          input logic [ADDR_W-1:0] awr, input logic [DATA_W-1:0] d0,
                          input logic [DATA_W-1:0] d1, input logic [BYTE_SELS-1:0] m0,
                          input logic [BYTE_SELS-1:0] m1);
        @(posedge core_clk);
        write_port_select_n   <= wn;
        read_port_select_n    <= rn;
        shared_addr           <= rn ? ~shared_addr : ard;
        write_data            <= wn ? ~write_data : d0;
        byte_write_select_n   <= wn ? ~byte_write_select_n : m0;
        nibble_write_select_n <= wn ? ~nibble_write_select_n : m0[1:0];
        repeat (2) @(posedge core_clk);
        pos_in_clk <= 1'b1;
        neg_in_clk <= 1'b0;
        repeat (7) @(posedge core_clk);
        seen_beat0  = read_data;
        seen_oe_n   = read_data_oe_n;
        shared_addr           <= wn ? ~shared_addr : awr;
        write_data            <= wn ? ~write_data : d1;
        byte_write_select_n   <= wn ? ~byte_write_select_n : m1;
        nibble_write_select_n <= wn ? ~nibble_write_select_n : m1[1:0];
        repeat (2) @(posedge core_clk);
        pos_in_clk <= 1'b0;
        neg_in_clk <= 1'b1;
        repeat (7) @(posedge core_clk);
        seen_beat1  = read_data;
    endtask : kcycle
endmodule : sswp_ctrl_model

`default_nettype wire

// >>> tb/sync_sram_write_addr_port_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sync_sram_write_addr_port_tb;
    import sswp_pkg::*;
    localparam int DW = X36_DATA_W;
    localparam int AW = ADDR_W_X36;
    logic                   core_clk = 1'b0;
    logic                   rst      = 1'b1;
    logic                   pos_in_clk, neg_in_clk, wsel_n, rsel_n, oe_n;
    logic [NIBBLE_SELS-1:0] nws_n;
    logic [BYTE_SELS-1:0]   bws_n;
    logic [AW-1:0]          addr;
    logic [DW-1:0]          wdata, rdata;
    int                     failures = 0;
    int                     n_tests  = 0;
    // second instance for the nibble-lane variant
    localparam int DW8 = NARROW_DATA_W;
    localparam int AW8 = ADDR_W_X8_X9;
    logic                   n8_pos, n8_neg, n8_wsel, n8_rsel, n8_oe;
    logic [NIBBLE_SELS-1:0] n8_nws;
    logic [BYTE_SELS-1:0]   n8_bws;
    logic [AW8-1:0]         n8_addr;
    logic [DW8-1:0]         n8_wdata, n8_rdata;

    always #10 core_clk = ~core_clk;

    sswp_top #(.DATA_W(DW), .ADDR_W(AW)) i_dut (.core_clk(core_clk), .rst(rst),
        .pos_in_clk(pos_in_clk), .neg_in_clk(neg_in_clk), .write_port_select_n(wsel_n),
        .read_port_select_n(rsel_n), .nibble_write_select_n(nws_n),
        .byte_write_select_n(bws_n), .shared_addr(addr), .write_data(wdata),
        .read_data(rdata), .read_data_oe_n(oe_n));

    sswp_ctrl_model #(.DATA_W(DW), .ADDR_W(AW)) i_ctrl (.core_clk(core_clk),
        .read_data(rdata), .read_data_oe_n(oe_n), .pos_in_clk(pos_in_clk),
        .neg_in_clk(neg_in_clk), .write_port_select_n(wsel_n),
        .read_port_select_n(rsel_n), .nibble_write_select_n(nws_n),
        .byte_write_select_n(bws_n), .shared_addr(addr), .write_data(wdata));

    sswp_top #(.DATA_W(DW8), .ADDR_W(AW8)) i_dut_x8 (.core_clk(core_clk), .rst(rst),
        .pos_in_clk(n8_pos), .neg_in_clk(n8_neg), .write_port_select_n(n8_wsel),
        .read_port_select_n(n8_rsel), .nibble_write_select_n(n8_nws),
        .byte_write_select_n(n8_bws), .shared_addr(n8_addr), .write_data(n8_wdata),
        .read_data(n8_rdata), .read_data_oe_n(n8_oe));

    sswp_ctrl_model #(.DATA_W(DW8), .ADDR_W(AW8)) i_ctrl_x8 (.core_clk(core_clk),
        .read_data(n8_rdata), .read_data_oe_n(n8_oe), .pos_in_clk(n8_pos),
        .neg_in_clk(n8_neg), .write_port_select_n(n8_wsel),
        .read_port_select_n(n8_rsel), .nibble_write_select_n(n8_nws),
        .byte_write_select_n(n8_bws), .shared_addr(n8_addr), .write_data(n8_wdata));

    task automatic chk_data(input string what, input logic [DW-1:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_data

    task automatic chk_flag(input string what, input logic exp, got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_flag

    // nine-bit lanes; a high select keeps the old lane
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_v, new_v,
                                            input logic [BYTE_SELS-1:0] m);
        for (int i = 0; i < DW; i++) merge[i] = m[i/BYTE_LANE_W] ? old_v[i] : new_v[i];
    endfunction : merge

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic idle();
        i_ctrl.kcycle(1'b1, 1'b1, '0, '0, '0, '0, '1, '1);
    endtask : idle

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d0, d1,
                      input logic [BYTE_SELS-1:0] m0, m1);
        i_ctrl.kcycle(1'b0, 1'b1, '0, a, d0, d1, m0, m1);
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e0, e1);
        i_ctrl.kcycle(1'b1, 1'b0, a, '0, '0, '0, '1, '1);
        idle();
        chk_flag("oe_n during burst", 1'b0, i_ctrl.seen_oe_n);
        chk_data("beat0", e0, i_ctrl.seen_beat0);
        chk_data("beat1", e1, i_ctrl.seen_beat1);
        idle();
        chk_flag("oe_n after burst", 1'b1, i_ctrl.seen_oe_n);
    endtask : rd

    task automatic t_full();
        wr(20'hfffff, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0);
        rd(20'hfffff, 36'h123456789, 36'hfedcba987);
    endtask : t_full

    task automatic t_mask();
        wr(20'hfffff, 36'h5a5a5a5a5, 36'ha5a5a5a5a, 4'ha, 4'h5);
        rd(20'hfffff, merge(36'h123456789, 36'h5a5a5a5a5, 4'ha),
           merge(36'hfedcba987, 36'ha5a5a5a5a, 4'h5));
    endtask : t_mask

    task automatic t_deselect();
        wr(20'h00000, 36'h111111111, 36'h222222222, 4'h0, 4'h0);
        wr(20'h00000, 36'h333333333, 36'h444444444, 4'h0, 4'hf);
        // released lines flip: this deselected frame shows lane-enabled data at address fffff
        i_ctrl.kcycle(1'b1, 1'b1, 20'hfffff, 20'hfffff, 36'h0, 36'h0, 4'h0, 4'h0);
        rd(20'h00000, 36'h333333333, 36'h222222222);
        rd(20'hfffff, merge(36'h123456789, 36'h5a5a5a5a5, 4'ha),
           merge(36'hfedcba987, 36'ha5a5a5a5a, 4'h5));
    endtask : t_deselect

    task automatic t_nibble();
        i_ctrl_x8.kcycle(1'b0, 1'b1, '0, 22'h3fffff, 8'h12, 8'h34, 4'h0, 4'h0);
        i_ctrl_x8.kcycle(1'b0, 1'b1, '0, 22'h3fffff, 8'hab, 8'hcd, 4'h2, 4'h1);
        i_ctrl_x8.kcycle(1'b1, 1'b0, 22'h3fffff, '0, '0, '0, 4'hf, 4'hf);
        i_ctrl_x8.kcycle(1'b1, 1'b1, '0, '0, '0, '0, 4'hf, 4'hf);
        chk_flag("x8 oe_n during burst", 1'b0, i_ctrl_x8.seen_oe_n);
        chk_data("x8 beat0", 36'h00000001b, {28'h0000000, i_ctrl_x8.seen_beat0});
        chk_data("x8 beat1", 36'h0000000c4, {28'h0000000, i_ctrl_x8.seen_beat1});
    endtask : t_nibble

    task automatic t_same_cycle();
        i_ctrl.kcycle(1'b0, 1'b0, 20'hfffff, 20'h00000, 36'h0f0f0f0f0, 36'hcafe01234,
                      4'h0, 4'h0);
        idle();
        chk_data("shared read beat0", merge(36'h123456789, 36'h5a5a5a5a5, 4'ha),
                 i_ctrl.seen_beat0);
        idle();
        rd(20'h00000, 36'h0f0f0f0f0, 36'hcafe01234);
    endtask : t_same_cycle

    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk_flag("oe_n after reset", 1'b1, oe_n);
        chk_data("read_data after reset", '0, rdata);
        t_full();
        t_mask();
        t_deselect();
        t_same_cycle();
        t_nibble();
        conclude();
    end

    // run needs about 525 core cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        $display("[FAIL] watchdog expected done seen hang");
        conclude();
    end
endmodule : sync_sram_write_addr_port_tb

`default_nettype wire
